// file: src/tsc_consts.svh
// tsc_consts.svh - offsets, field positions, reset values and counts
// for the transmit packet sourcer; definitions only, no logic.
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// apb register byte offsets, one aligned word each
`define TSC_OFS_CTRL    8'h00
`define TSC_OFS_PKT     8'h04
`define TSC_OFS_WPTR    8'h08
`define TSC_OFS_WDATA   8'h0c
`define TSC_OFS_STAT    8'h10
`define TSC_OFS_CRD_CPL 8'h14
`define TSC_OFS_CRD_NP  8'h18
`define TSC_OFS_CRD_P   8'h1c
`define TSC_OFS_HDR_CNT 8'h20
`define TSC_OFS_DAT_CNT 8'h24

// control register bit positions
`define TSC_CTRL_START  0
`define TSC_CTRL_NULEN  1
`define TSC_CTRL_RL2    2
`define TSC_CTRL_MPCEN  3
`define TSC_CTRL_MPCHI  4
`define TSC_CTRL_PAREN  5
`define TSC_CTRL_CLR    6
`define TSC_CTRL_KEEP   7'h3e
`define TSC_CTRL_RST    7'h04

// status register bit positions
`define TSC_STAT_BUSY   0
`define TSC_STAT_DONE   1
`define TSC_STAT_NREF   2
`define TSC_STAT_PERR   3
`define TSC_STAT_OVER   4
`define TSC_STAT_ARMED  5
`define TSC_STAT_INF    8

// packet register reset value
`define TSC_PKT_RST     18'h00000

// idle cycles after reset release before the first packet
`define TSC_RST_WAIT_CYC 2'h2

// credit vector lanes: headers on odd bits, data on even bits
`define TSC_HDR_MASK    6'h2a
`define TSC_DAT_MASK    6'h15

`endif

// file: src/tsc_crd_mon.sv
// tsc_crd_mon.sv - watches credit use pulses and returned byte parity.
// assumes credit and parity inputs come from logic on clk.
`timescale 1ns/1ns
`default_nettype none
`include "tsc_consts.svh"

module tsc_crd_mon #(
	parameter int DW = 256
) (
	// clock and synchronised reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// software controls
	input  wire logic            clr,
	input  wire logic            par_en,
	// beat on the stream and its parity
	input  wire logic            beat_valid,
	input  wire logic [DW-1:0]   beat_data,
	input  wire logic [DW/8-1:0] parity_in,
	// credit use pulses
	input  wire logic [5:0]      consumed,
	// results
	output logic      [15:0]     hdr_cnt_q,
	output logic      [15:0]     dat_cnt_q,
	output logic                 perr_q,
	output logic                 over_q
);
	// number of set bits among all six lanes; callers mask to three
	function automatic logic [1:0] cnt3(input logic [5:0] v);
		cnt3 = 2'(v[0]) + 2'(v[2]) + 2'(v[4]) +
		       2'(v[1]) + 2'(v[3]) + 2'(v[5]);
	endfunction

	logic [DW/8-1:0] par_exp;   // odd parity expected per byte
	logic [5:0]      hdr_v;     // header lanes this cycle
	logic [5:0]      dat_v;     // data lanes this cycle
	logic [1:0]      hdr_n;     // header credits this cycle
	logic [1:0]      dat_n;     // data credits this cycle
	logic            perr_set;  // parity mismatch now
	logic            over_set;  // illegal credit mix now

	// odd parity: a byte with an even count of ones gives a one
	for (genvar i = 0; i < DW / 8; i++) begin : g_par
		assign par_exp[i] = ~^beat_data[i*8 +: 8];
	end

	assign hdr_v    = consumed & `TSC_HDR_MASK;
	assign dat_v    = consumed & `TSC_DAT_MASK;
	assign hdr_n    = cnt3(hdr_v);
	assign dat_n    = cnt3(dat_v);
	assign perr_set = par_en & beat_valid & (parity_in != par_exp);
	// one header, or one header with one data credit, per cycle
	assign over_set = (hdr_n > 2'h1) | (dat_n > 2'h1) |
	                  ((dat_n != 2'h0) & (hdr_n == 2'h0));

	// counters wrap; sticky flags keep a set that meets a clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hdr_cnt_q <= 16'h0000;
			dat_cnt_q <= 16'h0000;
			perr_q    <= 1'b0;
			over_q    <= 1'b0;
		end else begin
			hdr_cnt_q <= clr ? 16'h0000 : hdr_cnt_q + 16'(hdr_n);
			dat_cnt_q <= clr ? 16'h0000 : dat_cnt_q + 16'(dat_n);
			perr_q    <= perr_set | (perr_q & ~clr);
			over_q    <= over_set | (over_q & ~clr);
		end
	end

endmodule
`default_nettype wire

// file: src/tsc_pkg.sv
// tsc_pkg.sv - types shared by the transmit packet sourcer.
// assumes tsc_consts.svh for every number.
package tsc_pkg;

	// packet engine states
	typedef enum logic [1:0] {
		TSC_IDLE,
		TSC_SEND,
		TSC_GAP
	} tsc_state_e;

	// per-beat sideband that travels with each payload word
	typedef struct packed {
		logic [1:0] first;
		logic [1:0] last;
		logic [1:0] empty;
		logic       nullify;
	} tsc_side_s;

	// packet description: length in words, nullify beat, empty code
	typedef struct packed {
		logic [1:0] empty;
		logic [7:0] nidx;
		logic [7:0] len;
	} tsc_pkt_s;

endpackage

// file: src/tsc_tx_ctrl.sv
// tsc_tx_ctrl.sv - application-side packet sourcer for a transaction
// layer transmit stream port, steered by software over apb.
// assumes the device port and the apb master both run on clk.
//
// Behaviour
// - word moves when valid meets ready cycle
// - valid stays up through packet unless throttled
// - valid drops one or two cycles after ready
// - valid returns within two cycles mid-packet
// - registered ready path gives latency two
// - empty code only on the last beat
// - 128-bit bus: empty bit 0 only
// - 256-bit bus: empty 1,2,3 trims dwords
// - dual mode lower end: last bit 0
// - dual mode upper end: last bit 1
// - nullify only posted or completion with data; packet type is not checked, any packet can be nullified
// - nullify pulse strictly inside packet, valid high
// - idle cycle after a nullified packet
// - no nullify for one or two beats
// - ready at n makes n+latency usable
// - wait two cycles after reset release
// - beat count matches the packet length
`timescale 1ns/1ns
`default_nettype none
`include "tsc_consts.svh"

module tsc_tx_ctrl
	import tsc_pkg::*;
#(
	parameter int DW    = 256, // payload width: 64, 128 or 256
	parameter int DEPTH = 16   // words the packet store holds
) (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// transmit stream towards the device
	output logic      [DW-1:0]   txq_payload_word,
	output logic                 txq_word_qualifier,
	input  wire logic            txq_accept_flag,
	output logic      [1:0]      txq_first_cycle,
	output logic      [1:0]      txq_last_cycle,
	output logic      [1:0]      txq_unused_dwords,
	output logic                 txq_nullify,
	input  wire logic [DW/8-1:0] txq_byte_odd_check,
	// credit reports from the device
	input  wire logic [11:0]     data_credit_cpl,
	input  wire logic [11:0]     data_credit_np,
	input  wire logic [11:0]     data_credit_p,
	input  wire logic [5:0]      credit_consumed,
	input  wire logic [5:0]      unlimited_credit_flags
);
	// true when an apb address hits a given register offset
	function automatic logic reg_hit(input logic [7:0] a,
	                                 input logic [7:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	// ---------------- reset release ----------------
	logic [1:0]   rst_sync_q;   // release pipe for the async reset
	logic         rst_i_n;      // synchronised reset for all logic

	// assert at once, release two edges later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_i_n = rst_sync_q[1];

	// ---------------- apb decode ----------------
	logic         sel_ctrl;     // control register
	logic         sel_pkt;      // packet description
	logic         sel_wptr;     // store dword pointer
	logic         sel_wdata;    // store data window
	logic         sel_stat;     // status
	logic         sel_ccpl;     // completion data credit limit
	logic         sel_cnp;      // non-posted data credit limit
	logic         sel_cp;       // posted data credit limit
	logic         sel_hcnt;     // header credits used
	logic         sel_dcnt;     // data credits used
	logic         sel_any;      // any mapped register
	logic         apb_acc;      // access phase not yet answered
	logic         wr_go;        // edge at which a write lands
	logic [31:0]  rd_data;      // read word before its register
	logic [31:0]  stat_word;    // status as software sees it

	assign sel_ctrl  = reg_hit(paddr, `TSC_OFS_CTRL);
	assign sel_pkt   = reg_hit(paddr, `TSC_OFS_PKT);
	assign sel_wptr  = reg_hit(paddr, `TSC_OFS_WPTR);
	assign sel_wdata = reg_hit(paddr, `TSC_OFS_WDATA);
	assign sel_stat  = reg_hit(paddr, `TSC_OFS_STAT);
	assign sel_ccpl  = reg_hit(paddr, `TSC_OFS_CRD_CPL);
	assign sel_cnp   = reg_hit(paddr, `TSC_OFS_CRD_NP);
	assign sel_cp    = reg_hit(paddr, `TSC_OFS_CRD_P);
	assign sel_hcnt  = reg_hit(paddr, `TSC_OFS_HDR_CNT);
	assign sel_dcnt  = reg_hit(paddr, `TSC_OFS_DAT_CNT);
	assign sel_any   = sel_ctrl | sel_pkt | sel_wptr | sel_wdata |
	                   sel_stat | sel_ccpl | sel_cnp | sel_cp |
	                   sel_hcnt | sel_dcnt;

	// one wait state: pready rises the cycle after access begins
	assign apb_acc = psel & penable & ~pready;
	// writes take effect only when the master samples pready high
	assign wr_go   = psel & penable & pready & pwrite;

	// ---------------- software registers ----------------
	logic [6:0]   ctrl_q;       // control bits kept between writes
	tsc_pkt_s     pkt_q;        // packet description
	logic [11:0]  wptr_q;       // dword pointer into the store
	logic         start_p;      // start pulse from software
	logic         clr_p;        // status clear pulse
	logic         buf_we;       // store write strobe
	logic         nul_en;       // nullify requested
	logic         rl2;          // ready latency two, else one
	logic         mpc_on;       // two-packets-per-cycle layout
	logic         mpc_hi;       // packet ends in the upper half
	logic         par_en;       // parity checking on

	assign start_p = wr_go & sel_ctrl & pwdata[`TSC_CTRL_START];
	assign clr_p   = wr_go & sel_ctrl & pwdata[`TSC_CTRL_CLR];
	assign buf_we  = wr_go & sel_wdata;
	assign nul_en  = ctrl_q[`TSC_CTRL_NULEN];
	assign rl2     = ctrl_q[`TSC_CTRL_RL2];
	// the split layout only exists on the widest bus
	assign mpc_on  = ctrl_q[`TSC_CTRL_MPCEN] & (DW == 256);
	assign mpc_hi  = ctrl_q[`TSC_CTRL_MPCHI];
	assign par_en  = ctrl_q[`TSC_CTRL_PAREN];

	// register writes; pulse bits are never stored
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ctrl_q <= `TSC_CTRL_RST;
			pkt_q  <= `TSC_PKT_RST;
			wptr_q <= 12'h000;
		end else begin
			if (wr_go && sel_ctrl) begin
				ctrl_q <= pwdata[6:0] & `TSC_CTRL_KEEP;
			end
			if (wr_go && sel_pkt) begin
				pkt_q <= tsc_pkt_s'(pwdata[17:0]);
			end
			// pointer advances per data write so bursts stream in
			if (wr_go && sel_wptr) begin
				wptr_q <= pwdata[11:0];
			end else if (buf_we) begin
				wptr_q <= wptr_q + 12'h001;
			end
		end
	end

	// ---------------- packet store ----------------
	logic [7:0]    idx_q;       // next word to put on the bus
	logic [DW-1:0] rd_word;     // word at idx_q

	tsc_word_buf #(
		.DW    (DW),
		.DEPTH (DEPTH)
	) u_buf (
		.clk   (clk),
		.we    (buf_we),
		.wptr  (wptr_q),
		.wdata (pwdata),
		.raddr (idx_q),
		.rdata (rd_word)
	);

	// ---------------- start-up hold-off ----------------
	logic [1:0]   arm_cnt_q;    // cycles since internal release
	logic         armed;        // packets may be issued

	// the device may show ready during reset; do not trust it early
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			arm_cnt_q <= 2'h0;
		end else if (!armed) begin
			arm_cnt_q <= arm_cnt_q + 2'h1;
		end
	end
	assign armed = (arm_cnt_q == `TSC_RST_WAIT_CYC);

	// ---------------- packet engine ----------------
	tsc_state_e   state_q;      // engine state
	tsc_state_e   state_d;
	logic         rdy_q;        // ready one cycle ago
	logic         rdy_cyc;      // next cycle is a ready cycle
	logic         null_go_q;    // this packet carries a nullify
	logic         null_ok;      // nullify position is legal
	logic         start_ok;     // start request accepted
	logic         fire;         // put a word out next cycle
	logic         last_w;       // idx_q is the final word
	logic         nref_q;       // nullify request was refused
	logic         done_q;       // a packet has completed
	logic [1:0]   empty_w;      // empty code as the bus needs it
	tsc_side_s    side_q;       // sideband on the bus
	tsc_side_s    side_d;
	logic [DW-1:0] data_q;      // payload on the bus
	logic         valid_q;      // qualifier on the bus

	// valid at t needs ready at t-latency; with latency two the
	// registered copy is used, so the ready path is one flop deep
	assign rdy_cyc = rl2 ? rdy_q : txq_accept_flag;

	assign last_w   = (idx_q == pkt_q.len - 8'h01);
	// strictly after the first beat, before the last, three or more
	assign null_ok  = (pkt_q.len >= 8'h03) &&
	                  (pkt_q.nidx != 8'h00) &&
	                  (pkt_q.nidx < pkt_q.len - 8'h01);
	assign start_ok = start_p && (state_q == TSC_IDLE) && armed &&
	                  (pkt_q.len != 8'h00) &&
	                  (pkt_q.len <= 8'(DEPTH));
	// a beat only in a ready cycle; none when throttled
	assign fire     = (state_q == TSC_SEND) && rdy_cyc;

	// empty code per bus width and layout
	assign empty_w =
		(DW == 64)  ? 2'b00 :
		(DW == 128) ? {1'b0, pkt_q.empty[0]} :
		(mpc_on && mpc_hi) ? {pkt_q.empty[0], 1'b0} :
		mpc_on ? {1'b0, pkt_q.empty[0]} :
		pkt_q.empty;

	// next sideband; everything idles low outside a beat
	always_comb begin
		side_d         = '0;
		side_d.first   = {1'b0, fire && (idx_q == 8'h00)};
		side_d.last[1] = fire && last_w && mpc_on && mpc_hi;
		side_d.last[0] = fire && last_w && !(mpc_on && mpc_hi);
		side_d.empty   = (fire && last_w) ? empty_w : 2'b00;
		// one-cycle nullify on an inner beat that carries valid
		side_d.nullify = fire && null_go_q &&
		                 (idx_q == pkt_q.nidx);
	end

	// state walk; a nullified packet is followed by one idle cycle
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			TSC_IDLE: begin
				if (start_ok) begin
					state_d = TSC_SEND;
				end
			end
			TSC_SEND: begin
				// exactly len beats, then stop
				if (fire && last_w) begin
					state_d = null_go_q ? TSC_GAP : TSC_IDLE;
				end
			end
			TSC_GAP: begin
				state_d = TSC_IDLE;
			end
		endcase
	end

	// engine registers
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			state_q   <= TSC_IDLE;
			rdy_q     <= 1'b0;
			idx_q     <= 8'h00;
			null_go_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rdy_q   <= txq_accept_flag;
			if (start_ok) begin
				idx_q     <= 8'h00;
				null_go_q <= nul_en && null_ok;
			end else if (fire) begin
				idx_q <= idx_q + 8'h01;
			end
		end
	end

	// bus registers; data holds its last value between beats
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			side_q  <= '0;
			valid_q <= 1'b0;
			data_q  <= '0;
		end else begin
			side_q  <= side_d;
			valid_q <= fire;
			if (fire) begin
				data_q <= rd_word;
			end
		end
	end

	assign txq_payload_word   = data_q;
	assign txq_word_qualifier = valid_q;
	assign txq_first_cycle    = side_q.first;
	assign txq_last_cycle     = side_q.last;
	assign txq_unused_dwords  = side_q.empty;
	assign txq_nullify        = side_q.nullify;

	// sticky status; a set in the clear cycle survives
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			done_q <= 1'b0;
			nref_q <= 1'b0;
		end else begin
			done_q <= (fire && last_w) | (done_q & ~clr_p);
			nref_q <= (start_ok && nul_en && !null_ok) |
			          (nref_q & ~clr_p);
		end
	end

	// ---------------- credit and parity watch ----------------
	logic [15:0]  hdr_cnt;      // header credits used
	logic [15:0]  dat_cnt;      // data credits used
	logic         perr;         // parity mismatch seen
	logic         over;         // illegal credit mix in a cycle

	tsc_crd_mon #(
		.DW         (DW)
	) u_mon (
		.clk        (clk),
		.rst_n      (rst_i_n),
		.clr        (clr_p),
		.par_en     (par_en),
		.beat_valid (valid_q),
		.beat_data  (data_q),
		.parity_in  (txq_byte_odd_check),
		.consumed   (credit_consumed),
		.hdr_cnt_q  (hdr_cnt),
		.dat_cnt_q  (dat_cnt),
		.perr_q     (perr),
		.over_q     (over)
	);

	// ---------------- read path ----------------
	assign stat_word = {18'h00000, unlimited_credit_flags,
	                    2'b00, armed, over, perr, nref_q, done_q,
	                    state_q != TSC_IDLE};

	// unmapped offsets read zero and flag an error
	assign rd_data =
		sel_ctrl ? {25'h0000000, ctrl_q} :
		sel_pkt  ? {14'h0000, pkt_q} :
		sel_wptr ? {20'h00000, wptr_q} :
		sel_stat ? stat_word :
		sel_ccpl ? {20'h00000, data_credit_cpl} :
		sel_cnp  ? {20'h00000, data_credit_np} :
		sel_cp   ? {20'h00000, data_credit_p} :
		sel_hcnt ? {16'h0000, hdr_cnt} :
		sel_dcnt ? {16'h0000, dat_cnt} :
		32'h00000000;

	// answer registers; read data is caught with pready
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_acc;
			if (apb_acc) begin
				prdata  <= pwrite ? 32'h00000000 : rd_data;
				pslverr <= ~sel_any;
			end
		end
	end

endmodule
`default_nettype wire

// file: src/tsc_word_buf.sv
// tsc_word_buf.sv - packet word store filled one dword at a time.
// assumes writes come from the apb side on the same clock.
`timescale 1ns/1ns
`default_nettype none

module tsc_word_buf #(
	parameter int DW    = 256,
	parameter int DEPTH = 16
) (
	// clock
	input  wire logic          clk,
	// dword write port
	input  wire logic          we,
	input  wire logic [11:0]   wptr,
	input  wire logic [31:0]   wdata,
	// word read port
	input  wire logic [7:0]    raddr,
	output logic      [DW-1:0] rdata
);
	localparam int LW = $clog2(DW / 32); // dword lane bits
	localparam int AW = $clog2(DEPTH);   // word address bits

	logic [DW-1:0]   mem_q [DEPTH];      // no reset: software fills it
	logic [11:0]     word_a;             // word part of dword pointer
	logic [LW-1:0]   lane_a;             // lane inside the word
	logic            in_range;           // pointer lands in the store

	assign word_a   = wptr >> LW;
	assign lane_a   = wptr[LW-1:0];
	assign in_range = word_a < 12'(DEPTH);

	// dword write; out of range writes are dropped quietly
	always_ff @(posedge clk) begin
		if (we && in_range) begin
			mem_q[word_a[AW-1:0]][{lane_a, 5'h00} +: 32] <= wdata;
		end
	end

	// read is combinational; the caller registers the word
	assign rdata = mem_q[raddr[AW-1:0]];

endmodule
`default_nettype wire

// file: tb/tb.sv
// tb.sv - apb driven checks of the transmit packet sourcer.
// assumes the device model answers the stream port.
`timescale 1ns/1ns
`default_nettype none
`include "tsc_consts.svh"
module tb;
	localparam logic [11:0] CNP  = 12'h040; // model limit
	localparam logic [5:0]  INFV = 6'h06;   // model flags
	logic         clk, rst_n, psel, penable, pwrite;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd, par;
	logic         pready, pslverr, er;
	logic [255:0] dat;
	logic         vld, rdy, nul, stl_q, bad_q, stall;
	logic [1:0]   fst, lst, emp;
	logic [11:0]  lc, ln, lp;
	logic [5:0]   cons, inf;
	logic [2:0]   cyc = 3'h0;
	int           failures, total_checks;
	logic [255:0] bd[$]; // captured beats
	logic [6:0]   bs[$]; // their sideband
	tsc_tx_ctrl #(.DW(256), .DEPTH(16)) u_dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txq_payload_word(dat),
		.txq_word_qualifier(vld), .txq_accept_flag(rdy),
		.txq_first_cycle(fst), .txq_last_cycle(lst),
		.txq_unused_dwords(emp), .txq_nullify(nul),
		.txq_byte_odd_check(par), .data_credit_cpl(lc),
		.data_credit_np(ln), .data_credit_p(lp),
		.credit_consumed(cons), .unlimited_credit_flags(inf));
	tsc_dev_model #(.NP(CNP), .INF(INFV)) u_dev (
		.clk(clk), .rst_n(rst_n), .data(dat), .valid(vld), .first(fst),
		.stall(stall), .bad_par(bad_q), .ready(rdy), .parity(par),
		.cred_cpl(lc), .cred_np(ln), .cred_p(lp), .consumed(cons),
		.inf_flags(inf));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// throttle: ready low three of eight cycles when enabled
	always @(posedge clk) begin
		cyc   <= cyc + 3'h1;
		stall <= stl_q && cyc > 3'h4;
	end
	// record every beat the sourcer puts out
	always @(posedge clk) begin
		if (vld === 1'b1) begin
			bd.push_back(dat);
			bs.push_back({fst, lst, emp, nul});
		end
	end
	task automatic chk(input logic [255:0] g, input logic [255:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one apb transfer; waits for pready, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin failures++; final_report(); end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, `TSC_OFS_STAT, 32'h0);
			n++;
		end while (rd[b] !== v && n < 100);
		if (n >= 100) begin failures++; final_report(); end
	endtask
	function automatic logic [255:0] ew(input int w);
		for (int k = 0; k < 8; k++) ew[32*k+:32] = 32'h1000 + w * 8 + k;
	endfunction
	// send one packet from words 0..len-1 and compare every beat
	task automatic run(input logic [5:0] c, input logic [7:0] len, nb,
		input logic [1:0] code, el, ee, input logic s, bp);
		logic       refused;
		logic [6:0] e;
		refused = c[1] && !(len > 2 && nb > 0 && nb < len - 1);
		bd.delete(); bs.delete(); stl_q <= s; bad_q <= bp;
		apb(1'b1, `TSC_OFS_CTRL, {25'h0, 1'b1, c}); // clear sticky bits
		apb(1'b1, `TSC_OFS_PKT, {14'h0, code, nb, len});
		apb(1'b1, `TSC_OFS_CTRL, {26'h0, c | 6'h01});
		poll(`TSC_STAT_BUSY, 1'b0);
		// the last beat's parity flag lands a cycle after busy falls
		apb(1'b0, `TSC_OFS_STAT, 32'h0);
		stl_q <= 1'b0;
		chk(bs.size(), len);
		for (int i = 0; i < bs.size(); i++) begin
			e = {(i == 0) ? 2'h1 : 2'h0, (i == len - 1) ? {el, ee} : 4'h0,
				c[1] && !refused && i == nb};
			chk(bd[i], ew(i));
			chk(bs[i], e);
		end
		chk(rd[3:2], {bp & c[5], refused});
		apb(1'b0, `TSC_OFS_HDR_CNT, 32'h0);
		chk(rd, 32'h1);
		$display("test len %0d code %0d done", len, code);
	endtask
	initial begin
		{psel, penable, pwrite, stl_q, bad_q} = '0;
		paddr = 8'h00; pwdata = 32'h0;
		failures = 0; total_checks = 0; rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		poll(`TSC_STAT_ARMED, 1'b1);
		apb(1'b0, `TSC_OFS_CTRL, 32'h0); chk(rd, 32'h4);
		apb(1'b0, 8'h28, 32'h0); chk({er, rd}, 33'h100000000);
		apb(1'b0, `TSC_OFS_CRD_NP, 32'h0); chk(rd, CNP);
		apb(1'b0, `TSC_OFS_STAT, 32'h0); chk(rd[13:8], INFV);
		apb(1'b1, `TSC_OFS_WPTR, 32'h0);
		for (int i = 0; i < 32; i++) apb(1'b1, `TSC_OFS_WDATA, 32'h1000 + i);
		run(6'h04, 4, 0, 1, 1, 1, 0, 0);
		run(6'h06, 4, 1, 3, 1, 3, 1, 0);
		run(6'h06, 4, 2, 2, 1, 2, 0, 0);
		run(6'h06, 2, 1, 2, 1, 2, 0, 0);
		run(6'h04, 1, 0, 0, 1, 0, 0, 0);
		run(6'h0c, 2, 0, 3, 1, 1, 0, 0);
		run(6'h1c, 2, 0, 1, 2, 2, 0, 0);
		run(6'h24, 3, 0, 0, 1, 0, 0, 1);
		run(6'h24, 2, 0, 0, 1, 0, 1, 0);
		run(6'h00, 3, 0, 2, 1, 2, 0, 0);
		final_report();
	end
endmodule
`default_nettype wire

// file: tb/tsc_dev_model.sv
// tsc_dev_model.sv - behavioural device end of the transmit port.
// assumes the sourcer runs on the same clk; empty is never read.
`timescale 1ns/1ns
`default_nettype none
module tsc_dev_model #(
	parameter logic [11:0] CPL = 12'h0a0, // arbitrary limits
	parameter logic [11:0] NP  = 12'h040,
	parameter logic [11:0] PD  = 12'h120,
	parameter logic [5:0]  INF = 6'h06
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// stream from the sourcer
	input  wire logic [255:0] data,
	input  wire logic         valid,
	input  wire logic [1:0]   first,
	// bench commands: throttle, corrupt parity
	input  wire logic         stall,
	input  wire logic         bad_par,
	// device outputs
	output logic              ready,
	output logic      [31:0]  parity,
	output logic      [11:0]  cred_cpl,
	output logic      [11:0]  cred_np,
	output logic      [11:0]  cred_p,
	output logic      [5:0]   consumed,
	output logic      [5:0]   inf_flags
);
	// static limits and flags keep the compare simple
	assign cred_cpl  = CPL;
	assign cred_np   = NP;
	assign cred_p    = PD;
	assign inf_flags = INF;
	// odd parity per byte, bit 0 over bits 7:0
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			parity[i] = ~^data[8*i+:8] ^ bad_par;
		end
	end
	// word taken when valid meets ready; one header plus data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready    <= 1'b0;
			consumed <= 6'h00;
		end else begin
			ready    <= !stall;
			consumed <= (valid && first[0]) ? 6'h30 : 6'h00;
		end
	end
endmodule
`default_nettype wire

// file: tb/tsc_tx_ctrl_sva.sv
// tsc_tx_ctrl_sva.sv - port checks on the transmit packet sourcer.
// assumes ready latency two (the reset value) whenever ready drops.
`timescale 1ns/1ns
`default_nettype none
module tsc_tx_ctrl_sva (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// apb handshake
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	// stream towards the device
	input wire logic       txq_word_qualifier,
	input wire logic       txq_accept_flag,
	input wire logic [1:0] txq_first_cycle,
	input wire logic [1:0] txq_last_cycle,
	input wire logic [1:0] txq_unused_dwords,
	input wire logic       txq_nullify
);
	logic in_pkt_q; // first beat seen, last not yet
	logic nul_q;    // nullify seen in this packet
	wire  v = txq_word_qualifier;
	// framing tracker; cleared on the last beat
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_pkt_q <= 1'b0;
			nul_q    <= 1'b0;
		end else if (v) begin
			in_pkt_q <= txq_last_cycle == 2'h0;
			nul_q    <= (nul_q | txq_nullify) & (txq_last_cycle == 2'h0);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_end_nul;
		v && txq_last_cycle != 2'h0 && nul_q;
	endsequence
	AST_APB_ONE_WAIT: assert property (s_acc |=> pready)
		else $error("apb answer not one wait state");
	AST_APB_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_RDY_CYCLE: assert property (v |-> $past(txq_accept_flag, 2))
		else $error("beat outside a ready cycle");
	AST_HOLD_VALID: assert property (in_pkt_q && $past(txq_accept_flag, 2) |-> v)
		else $error("valid dropped mid packet");
	AST_EMPTY_LAST: assert property (txq_unused_dwords != 2'h0 |-> v && txq_last_cycle != 2'h0)
		else $error("empty code off the last beat");
	AST_FIRST_VALID: assert property (txq_first_cycle != 2'h0 |-> v && txq_first_cycle == 2'h1 && !in_pkt_q)
		else $error("bad start marker");
	AST_NULL_INNER: assert property (txq_nullify |-> v && in_pkt_q && txq_last_cycle == 2'h0)
		else $error("nullify not on an inner beat");
	AST_NULL_GAP: assert property (s_end_nul |=> !v ##1 !v)
		else $error("no idle cycle after nullified packet");
	AST_LAST_ONE: assert property (txq_last_cycle != 2'h0 |-> v && txq_last_cycle != 2'h3)
		else $error("bad end marker");
endmodule
bind tsc_tx_ctrl tsc_tx_ctrl_sva u_sva (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pready(pready), .txq_word_qualifier(txq_word_qualifier),
	.txq_accept_flag(txq_accept_flag), .txq_first_cycle(txq_first_cycle),
	.txq_last_cycle(txq_last_cycle), .txq_unused_dwords(txq_unused_dwords),
	.txq_nullify(txq_nullify));
`default_nettype wire
